// ---- include/ccp_pkg.sv ----
// Package with constants and types of the counter compare PWM block.
//
// Functional notes
// - Event mode starts on first active edge
// - Event mode enabled by event_count_mode bit
// - Event input inverted when input_invert set
// - Debouncer on when debounce_disable clear, rate selectable
// - Counter equal compare value raises match_irq
// - No match_irq while compare_enable clear
// - Starting at compare value raises nothing
// - Every load clears compare_enable
// - Full width compare uses all ten bits
// - Route enable stops counter after match
// - Limited compare uses selected length bits
// - PWM held at start level while disabled
// - Route enable puts PWM on pin output; pin driven only while pb_dir set
// - PWM match always uses selected length
// - Upper compare bits set pulse count
// - Up mode: roll-over high, match low
// - Down mode: roll-over low, match high
// - Interrupt requests continue during PWM output
// - Roll-over at all ones up, zero down
// - Counter steps by one and wraps

package ccp_pkg;

	// ----------------------------------------------------------------
	// Register offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h04;
	localparam logic [7:0] ADDR_DATA  = 8'h08;
	localparam logic [7:0] ADDR_SYS   = 8'h0c;
	localparam logic [7:0] ADDR_PRESC = 8'h10;
	localparam logic [7:0] ADDR_PAOPT = 8'h14;
	localparam logic [7:0] ADDR_PB    = 8'h18;
	localparam logic [7:0] ADDR_STAT  = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int B_UP    = 0;
	localparam int B_FSEL  = 1;
	localparam int B_LOAD  = 0;
	localparam int B_CEN   = 1;
	localparam int B_EVM   = 2;
	localparam int B_START = 3;
	localparam int B_LEN   = 10;
	localparam int B_FULL  = 1;
	localparam int B_ROUTE = 0;
	localparam int B_DRATE = 1;
	localparam int B_INV   = 0;
	localparam int B_DDIS  = 2;
	localparam int B_PBDAT = 0;
	localparam int B_PBDIR = 1;

	// ----------------------------------------------------------------
	// Values, reset values and counts.
	// ----------------------------------------------------------------
	localparam int         CNT_W     = 10;
	localparam logic [2:0] FSEL_PA0  = 3'h0;
	localparam logic [2:0] FSEL_PA3  = 3'h7;
	localparam logic [9:0] RST_CNT   = 10'h000;
	localparam logic [9:0] LEN_MASK [4] = '{10'h3ff, 10'h0ff, 10'h03f, 10'h00f};
	localparam int         DEB_SLOW_W = 8;
	localparam int         DEB_FAST_W = 5;

	// Counter start sequence states.
	typedef enum logic [2:0] {
		CS_IDLE = 3'b001,
		CS_ARM  = 3'b010,
		CS_RUN  = 3'b100
	} ccp_state_t;

endpackage

// ---- include/ccp_evt_if.sv ----
// Interface between the core and the event input conditioner.
`timescale 1ns/1ps
interface ccp_evt_if;
	logic [1:0] pin;
	logic [1:0] invert;
	logic [1:0] deb_dis;
	logic       rate_sel;
	logic [1:0] rise;
	modport cond (input pin, invert, deb_dis, rate_sel, output rise);
	modport core (output pin, invert, deb_dis, rate_sel, input rise);
endinterface

// ---- rtl/ccp_evt_cond.sv ----
// Event input synchroniser, debouncer, polarity select and edge detector.
`timescale 1ns/1ps
module ccp_evt_cond import ccp_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	ccp_evt_if.cond  ev
);
	logic [DEB_SLOW_W-1:0] div;
	logic [DEB_SLOW_W-1:0] next_div;
	logic                  samp;

	// ----------------------------------------------------------------
	// Sample rate divider.
	// ----------------------------------------------------------------
	// Slow rate samples every full wrap, fast rate on the low bits.
	always_comb begin
		next_div = div + DEB_SLOW_W'(1);
		samp     = ev.rate_sel ? (div == '1) : (div[DEB_FAST_W-1:0] == '1);
	end

	// Divider register.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			div <= '0;
		end else begin
			div <= next_div;
		end
	end

	// ----------------------------------------------------------------
	// Per channel conditioning.
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic s1, s2, deb, lvl, next_deb, next_lvl;

		// Debounced level holds the last sample; inversion follows.
		always_comb begin
			next_deb = samp ? s2 : deb;
			next_lvl = (ev.deb_dis[i] ? s2 : deb) ^ ev.invert[i];
		end

		// Two flop synchroniser and level registers.
		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				s1  <= 1'b0;
				s2  <= 1'b0;
				deb <= 1'b0;
				lvl <= 1'b0;
			end else begin
				s1  <= ev.pin[i];
				s2  <= s1;
				deb <= next_deb;
				lvl <= next_lvl;
			end
		end

		// Rising edge of the conditioned level counts as an event.
		assign ev.rise[i] = next_lvl & ~lvl;
	end

endmodule // ccp_evt_cond

// ---- rtl/ccp_top.sv ----
// Counter with compare, event counting and PWM output, on an APB slave.
`timescale 1ns/1ps
module ccp_top import ccp_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        event_input_zero,
	input  wire logic        event_input_three,
	input  wire logic        fastest_prescaler_tick,
	output logic             pwm_pin_o,
	output logic             pwm_pin_oe_n,
	output logic             match_irq,
	output logic             rollover_irq
);
	// ----------------------------------------------------------------
	// Declarations.
	// ----------------------------------------------------------------
	ccp_evt_if ev ();

	logic        up, next_up;
	logic [2:0]  fsel, next_fsel;
	logic [9:0]  cmpv, next_cmpv;
	logic [1:0]  len, next_len;
	logic        full, next_full;
	logic        route, next_route;
	logic        drate, next_drate;
	logic [1:0]  inv, next_inv;
	logic [1:0]  ddis, next_ddis;
	logic        pb_data, next_pb_data;
	logic        pb_dir, next_pb_dir;
	logic [31:0] next_prdata, rd_val;
	logic        next_pready, next_pslverr;

	ccp_state_t  state, next_state;
	logic [9:0]  count, next_count;
	logic        start, next_start;
	logic        evm, next_evm;
	logic        cen, next_cen;
	logic        pwm, next_pwm;
	logic        next_mirq, next_rirq, next_pin, next_oe_n;

	logic        hit, setup, wr, wr_c2, ld, flip, tick, step;
	logic [9:0]  mask, stepped;
	logic        roll, lm, fm;

	// ----------------------------------------------------------------
	// Event input conditioner.
	// ----------------------------------------------------------------
	assign ev.pin      = {event_input_three, event_input_zero};
	assign ev.invert   = inv;
	assign ev.deb_dis  = ddis;
	assign ev.rate_sel = drate;

	ccp_evt_cond u_cond (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ev      (ev)
	);

	// ----------------------------------------------------------------
	// Decode and counting helpers.
	// ----------------------------------------------------------------
	// Write takes effect at the edge that ends the access phase.
	assign hit     = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STAT);
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pready & pwrite & hit;
	assign wr_c2   = wr && (paddr == ADDR_CTRL2);
	assign ld      = wr_c2 && pwdata[B_LOAD];
	assign flip    = wr && (paddr == ADDR_CTRL1) && (pwdata[B_UP] != up);
	assign tick    = (fsel == FSEL_PA0) ? ev.rise[0] :
	                 (fsel == FSEL_PA3) ? ev.rise[1] : fastest_prescaler_tick;
	assign step    = (state == CS_RUN) && start && tick;
	assign mask    = LEN_MASK[len];
	assign stepped = up ? count + 10'h001 : count - 10'h001;
	assign roll    = (stepped & mask) == (up ? mask : 10'h000);
	assign lm      = (stepped & mask) == (cmpv & mask);
	assign fm      = full ? (stepped == cmpv) : lm;

	// ----------------------------------------------------------------
	// Read data multiplexer.
	// ----------------------------------------------------------------
	// Unused and reserved bits read as zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
		ADDR_CTRL1: rd_val[3:0] = {fsel, up};
		ADDR_CTRL2: rd_val[3:0] = {start, evm, cen, 1'b0};
		ADDR_DATA:  rd_val[11:0] = {len, count};
		ADDR_SYS:   rd_val[B_FULL] = full;
		ADDR_PRESC: rd_val[1:0] = {drate, route};
		ADDR_PAOPT: rd_val[3:0] = {ddis, inv};
		ADDR_PB:    rd_val[1:0] = {pb_dir, pb_data};
		ADDR_STAT:  rd_val[1:0] = {state == CS_RUN, pwm};
		default:    rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus and configuration registers.
	// ----------------------------------------------------------------
	// Ready, read data and error are captured at the setup edge.
	always_comb begin
		next_pready  = setup;
		next_pslverr = setup & ~hit;
		next_prdata  = setup ? rd_val : prdata;
		next_up      = up;
		next_fsel    = fsel;
		next_cmpv    = cmpv;
		next_len     = len;
		next_full    = full;
		next_route   = route;
		next_drate   = drate;
		next_inv     = inv;
		next_ddis    = ddis;
		next_pb_data = pb_data;
		next_pb_dir  = pb_dir;
		if (wr) begin
			case (paddr)
			ADDR_CTRL1: begin
				next_up   = pwdata[B_UP];
				next_fsel = pwdata[B_FSEL+:3];
			end
			ADDR_DATA: begin
				next_cmpv = pwdata[CNT_W-1:0];
				next_len  = pwdata[B_LEN+:2];
			end
			ADDR_SYS:   next_full = pwdata[B_FULL];
			ADDR_PRESC: begin
				next_route = pwdata[B_ROUTE];
				next_drate = pwdata[B_DRATE];
			end
			ADDR_PAOPT: begin
				next_inv  = pwdata[B_INV+:2];
				next_ddis = pwdata[B_DDIS+:2];
			end
			ADDR_PB: begin
				next_pb_data = pwdata[B_PBDAT];
				next_pb_dir  = pwdata[B_PBDIR];
			end
			default: next_up = up;
			endcase
		end
	end

	// Registers of the bus group.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			up      <= 1'b0;
			fsel    <= FSEL_PA0;
			cmpv    <= RST_CNT;
			len     <= 2'h0;
			full    <= 1'b0;
			route   <= 1'b0;
			drate   <= 1'b0;
			inv     <= 2'h0;
			ddis    <= 2'h0;
			pb_data <= 1'b0;
			pb_dir  <= 1'b0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
			up      <= next_up;
			fsel    <= next_fsel;
			cmpv    <= next_cmpv;
			len     <= next_len;
			full    <= next_full;
			route   <= next_route;
			drate   <= next_drate;
			inv     <= next_inv;
			ddis    <= next_ddis;
			pb_data <= next_pb_data;
			pb_dir  <= next_pb_dir;
		end
	end

	// ----------------------------------------------------------------
	// Counter, compare and PWM.
	// ----------------------------------------------------------------
	// Outside event mode the first counting edge only arms the counter,
	// so a clock caught mid-period never gives a short first step.
	always_comb begin
		next_state = state;
		next_count = count;
		next_start = start;
		next_evm   = evm;
		next_cen   = cen;
		next_pwm   = pwm;
		next_mirq  = 1'b0;
		next_rirq  = 1'b0;
		next_pin   = route ? pwm : pb_data;
		next_oe_n  = ~pb_dir;
		if (wr_c2) begin
			next_start = pwdata[B_START];
			next_evm   = pwdata[B_EVM];
			next_cen   = pwdata[B_CEN];
		end
		case (state)
		CS_IDLE: begin
			if (start) begin
				next_state = evm ? CS_RUN : CS_ARM;
			end
		end
		CS_ARM: begin
			if (!start) begin
				next_state = CS_IDLE;
			end else if (tick) begin
				next_state = CS_RUN;
			end
		end
		CS_RUN: begin
			if (!start) begin
				next_state = CS_IDLE;
			end
		end
		default: next_state = CS_IDLE;
		endcase
		// Matches are only judged on a new counter value, never at start.
		if (step) begin
			next_count = stepped;
			next_rirq  = roll;
			next_mirq  = cen & fm;
			if (cen) begin
				if (lm) begin
					next_pwm = ~up;
				end else if (roll) begin
					next_pwm = up;
				end
				if (fm && route) begin
					next_start = 1'b0;
				end
			end
		end
		if (!cen) begin
			next_pwm = ~up;
		end
		// Changing direction inverts the count; a load overrides all.
		if (flip) begin
			next_count = ~count;
		end
		if (ld) begin
			next_count = cmpv;
			next_cen   = 1'b0;
			if (cmpv == RST_CNT) begin
				next_start = 1'b0;
			end
		end
	end

	// Registers of the counter group.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state        <= CS_IDLE;
			count        <= RST_CNT;
			start        <= 1'b0;
			evm          <= 1'b0;
			cen          <= 1'b0;
			pwm          <= 1'b1;
			match_irq    <= 1'b0;
			rollover_irq <= 1'b0;
			pwm_pin_o    <= 1'b0;
			pwm_pin_oe_n <= 1'b1;
		end else begin
			state        <= next_state;
			count        <= next_count;
			start        <= next_start;
			evm          <= next_evm;
			cen          <= next_cen;
			pwm          <= next_pwm;
			match_irq    <= next_mirq;
			rollover_irq <= next_rirq;
			pwm_pin_o    <= next_pin;
			pwm_pin_oe_n <= next_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_evm_start;
		$rose(start) && evm |=> state == CS_RUN;
	endproperty
	a_evm_start: assert property (p_evm_start) else $error("event start late");

	property p_no_match_off;
		!cen |=> !match_irq;
	endproperty
	a_no_match_off: assert property (p_no_match_off) else $error("match while off");

	property p_load_clears;
		ld |=> !cen && count == $past(cmpv);
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("load kept enable");

	property p_full_cmp;
		step && cen && full && (stepped != cmpv) |=> !match_irq;
	endproperty
	a_full_cmp: assert property (p_full_cmp) else $error("partial match fired");

	property p_autostop;
		match_irq && $past(route) |-> !start ##1 state == CS_IDLE;
	endproperty
	a_autostop: assert property (p_autostop) else $error("no stop on match");

	property p_hold_level;
		!cen |=> pwm == !$past(up);
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("start level lost");

	property p_route;
		route |=> pwm_pin_o == $past(pwm);
	endproperty
	a_route: assert property (p_route) else $error("pin not routed");

	property p_up_edges;
		step && cen && up && roll && !lm |=> pwm;
	endproperty
	a_up_edges: assert property (p_up_edges) else $error("up roll not high");

	property p_dn_match;
		step && cen && !up && lm |=> pwm;
	endproperty
	a_dn_match: assert property (p_dn_match) else $error("down match not high");

	property p_step_up;
		step && up && !ld && !flip |=> count == 10'($past(count) + 10'h001);
	endproperty
	a_step_up: assert property (p_step_up) else $error("bad up step");

endmodule // ccp_top

// ---- tb/ccp_pins_model.sv ----
// Model of the port pins around the block: event sources and the pulled-down PWM pin.
`timescale 1ns/1ps
module ccp_pins_model (
	input  wire logic sys_clk,
	input  wire logic pwm_pin_o,
	input  wire logic pwm_pin_oe_n,
	output logic      event_input_zero,
	output logic      event_input_three,
	output logic      pin_level
);
	// The pin has a pull-down, so an undriven pin reads low.
	assign pin_level = (pwm_pin_oe_n === 1'b0) ? pwm_pin_o : 1'b0;

	initial begin
		event_input_zero = 1'b0;
		event_input_three = 1'b0;
	end

	// Sets one event input to a level just after a clock edge.
	task automatic drive(input logic sel, input logic v);
		@(posedge sys_clk);
		if (sel) event_input_three <= v;
		else event_input_zero <= v;
	endtask

	// One event pulse: high for hi+1 cycles, then low for lo cycles.
	task automatic pulse(input logic sel, input int hi, input int lo);
		drive(sel, 1'b1);
		repeat (hi) @(posedge sys_clk);
		drive(sel, 1'b0);
		repeat (lo) @(posedge sys_clk);
	endtask
endmodule // ccp_pins_model

// ---- tb/counter_compare_pwm_event_tb.sv ----
// Self-checking bench of the counter compare PWM block.
`timescale 1ns/1ps
module counter_compare_pwm_event_tb import ccp_pkg::*; ;
	logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tick = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, pwm_pin_o, pwm_pin_oe_n, match_irq, rollover_irq;
	logic        ev0, ev3, pin_level, err, up, last_pin = 0;
	logic [9:0]  st, cm;
	logic [5:0]  nn;
	logic [3:0]  lo;
	int          num_errors = 0, n_tests = 0, n_match = 0, n_roll = 0, n_tog = 0, k;
	integer      seed = 32'h1ab1;

	ccp_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_input_zero(ev0), .event_input_three(ev3),
		.fastest_prescaler_tick(tick), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_n(pwm_pin_oe_n),
		.match_irq(match_irq), .rollover_irq(rollover_irq));
	ccp_pins_model i_pins (.sys_clk(sys_clk), .pwm_pin_o(pwm_pin_o),
		.pwm_pin_oe_n(pwm_pin_oe_n), .event_input_zero(ev0), .event_input_three(ev3),
		.pin_level(pin_level));

	// Clock and a prescaler tick at half the clock rate.
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) tick <= rst_n & ~tick;

	// Counts pulses and pin changes away from the sampling edge.
	always @(negedge sys_clk) begin
		if (match_irq === 1'b1) n_match++;
		if (rollover_irq === 1'b1) n_roll++;
		if (pin_level !== last_pin) n_tog++;
		last_pin = pin_level;
	end

	// --------------------------------------------------------------
	// Shared tasks and expectations.
	// --------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Steps a counter from s until the full compare value, counting roll-overs.
	function automatic int rolls(logic [9:0] s, logic [9:0] c, int l, logic u);
		int n = 0;
		for (int i = 0; i < 1024; i++) begin
			s = u ? s + 10'h1 : s - 10'h1;
			if ((s & LEN_MASK[l]) == (u ? LEN_MASK[l] : 10'h0)) n++;
			if (s == c) return n;
		end
		return -1;
	endfunction

	// --------------------------------------------------------------
	// Main sequence.
	// --------------------------------------------------------------
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1;
		chk("oe_n", 1, pwm_pin_oe_n);
		apb(1'b0, 8'h20, 0);
		chk("slverr", 1, err);
		chk("unmapped", 0, rd);
		// Limited pulse trains on a 4-bit counter with full compare, both directions.
		for (int i = 0; i < 4; i++) begin
			up = i[0];
			nn = 6'h1 + 6'($random(seed) & 3);
			lo = 4'h1 + 4'(($random(seed) & 255) % 14);
			// Down trains start at zero so the first wrap is the first pulse.
			st = up ? {6'($random(seed) & 7), 4'h0} : 10'h000;
			cm = up ? {st[9:4] + nn, lo} : {~nn, lo};
			wr(ADDR_CTRL2, 0);
			wr(ADDR_CTRL1, {28'h0, 3'h1, up});
			wr(ADDR_DATA, 32'hc00 | 32'(st));
			wr(ADDR_CTRL2, 1);
			wr(ADDR_SYS, 2);
			wr(ADDR_PRESC, 1);
			wr(ADDR_PB, 2);
			repeat (2) @(posedge sys_clk);
			chk("start level", 32'(!up), pin_level);
			wr(ADDR_DATA, 32'hc00 | 32'(cm));
			n_match = 0; n_roll = 0; n_tog = 0;
			wr(ADDR_CTRL2, 32'ha);
			for (k = 0; k < 3000 && n_match == 0; k++) @(posedge sys_clk);
			repeat (20) @(posedge sys_clk);
			chk("match", 1, n_match);
			chk("rolls", rolls(st, cm, 3, up), n_roll);
			chk("toggles", 2 * rolls(st, cm, 3, up), n_tog);
			apb(1'b0, ADDR_DATA, 0);
			chk("stopped count", cm, rd[9:0]);
			apb(1'b0, ADDR_STAT, 0);
			chk("running", 0, rd[1]);
		end
		// Limited 8-bit compare, start at the compare value, no routing.
		wr(ADDR_CTRL2, 0);
		wr(ADDR_CTRL1, 3);
		wr(ADDR_PRESC, 0);
		wr(ADDR_SYS, 0);
		st = 10'h100 | 10'($random(seed) & 255);
		wr(ADDR_DATA, 32'h400 | 32'(st));
		wr(ADDR_CTRL2, 1);
		n_match = 0;
		wr(ADDR_CTRL2, 32'ha);
		repeat (100) @(posedge sys_clk);
		chk("start match", 0, n_match);
		for (k = 0; k < 700 && n_match == 0; k++) @(posedge sys_clk);
		chk("limited match", 1, n_match);
		apb(1'b0, ADDR_STAT, 0);
		chk("keeps running", 1, rd[1]);
		wr(ADDR_CTRL2, 32'hb);
		apb(1'b0, ADDR_CTRL2, 0);
		chk("cen after load", 0, rd[1]);
		wr(ADDR_CTRL2, 32'h8);
		n_match = 0;
		repeat (600) @(posedge sys_clk);
		chk("disabled match", 0, n_match);
		wr(ADDR_PB, 3);
		repeat (2) @(posedge sys_clk);
		chk("port data", 1, pin_level);
		// Event counting on input zero inverted, then input three debounced.
		wr(ADDR_CTRL2, 0);
		wr(ADDR_CTRL1, 1);
		wr(ADDR_PAOPT, 32'hd);
		wr(ADDR_DATA, 0);
		wr(ADDR_CTRL2, 1);
		wr(ADDR_CTRL2, 32'hc);
		i_pins.drive(1'b0, 1'b1);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, ADDR_DATA, 0);
		chk("inverted rise", 0, rd[9:0]);
		i_pins.drive(1'b0, 1'b0);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, ADDR_DATA, 0);
		chk("first event", 1, rd[9:0]);
		k = 2 + ($random(seed) & 3);
		repeat (k) i_pins.pulse(1'b1 ^ 1'b1, 4, 4);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, ADDR_DATA, 0);
		chk("events", 32'(1 + k), rd[9:0]);
		wr(ADDR_CTRL2, 0);
		wr(ADDR_CTRL1, 32'hf);
		wr(ADDR_PAOPT, 0);
		wr(ADDR_CTRL2, 32'hc);
		repeat (3) i_pins.pulse(1'b1, 80, 80);
		apb(1'b0, ADDR_DATA, 0);
		chk("debounced", 32'(4 + k), rd[9:0]);
		// Slow debounce rate: one long pulse still counts once.
		wr(ADDR_PRESC, 2);
		i_pins.pulse(1'b1, 300, 300);
		apb(1'b0, ADDR_DATA, 0);
		chk("slow debounced", 32'(5 + k), rd[9:0]);
		tally_and_finish();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#6000000;
		num_errors++;
		tally_and_finish();
	end
endmodule // counter_compare_pwm_event_tb
